// File: pkg/bcp_pkg.sv
// package: register map, field positions, codes and reset values
package bcp_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CHOP_CHANNEL_CONTROL = 8'h00;
    localparam logic [7:0] OFS_CHOP_CHANNEL_FLAGS   = 8'h04;
    localparam logic [7:0] OFS_CHOP_IRQ_ENABLES     = 8'h08;
    localparam logic [7:0] OFS_CHOP_COUNTER         = 8'h0c;
    localparam logic [7:0] OFS_CHOP_PERIOD_COMPARE  = 8'h10;
    localparam logic [7:0] OFS_CHOP_DUTY_COMPARE_B  = 8'h14;
    localparam logic [7:0] OFS_CHOP_DUTY_COMPARE_C  = 8'h18;
    localparam logic [7:0] OFS_CHOP_DUTY_COMPARE_D  = 8'h1c;
    localparam logic [7:0] OFS_PWM_MODE_SELECT      = 8'h20;
    localparam logic [7:0] OFS_OUTPUT_MASTER_ENABLE = 8'h24;
    localparam logic [7:0] OFS_INITIAL_OUTPUT_LEVEL = 8'h28;
    localparam logic [7:0] OFS_PORT_DATA_REG        = 8'h2c;
    localparam logic [7:0] OFS_PORT_DIRECTION_REG   = 8'h30;
    localparam logic [7:0] OFS_EDGE_SELECT_REG      = 8'h34;
    localparam logic [7:0] OFS_EXT_IRQ_ENABLE_REG   = 8'h38;
    localparam logic [7:0] OFS_EXT_IRQ_REQUEST_REG  = 8'h3c;

    // ------------------------------------------------------------
    // fields
    // ------------------------------------------------------------
    localparam int unsigned CTRL_PRESCALE_LSB = 0;
    localparam int unsigned CTRL_CLEAR_LSB    = 3;
    localparam int unsigned FAULT_INTERRUPT_PIN_BIT          = 0;

    // prescale select codes; every code from 4 up counts the external clock
    localparam logic [2:0] PSC_DIV1 = 3'h0;
    localparam logic [2:0] PSC_DIV2 = 3'h1;
    localparam logic [2:0] PSC_DIV4 = 3'h2;
    localparam logic [2:0] PSC_DIV8 = 3'h3;

    // counter clear select codes
    localparam logic [2:0] CCLR_NONE = 3'h0;
    localparam logic [2:0] CCLR_A    = 3'h1;
    localparam logic [2:0] CCLR_B    = 3'h2;
    localparam logic [2:0] CCLR_C    = 3'h3;
    localparam logic [2:0] CCLR_D    = 3'h4;
    localparam logic [2:0] CCLR_EXT  = 3'h5;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_HALF = 16'h0000;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WRITE,
        BUS_READ
    } bcp_bus_type;

endpackage

// File: rtl/bcp_fault_edge.sv
// module: fault pin synchroniser and selectable edge detector
`timescale 1ns/1ps
module bcp_fault_edge (
    input  wire logic clk_sys,
    input  wire logic arst_n,
    input  wire logic pinIn,
    input  wire logic risingSel,
    output logic      edgePulse
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic pulse;
    } bcp_edge_state_type;

    bcp_edge_state_type st;
    bcp_edge_state_type next_st;

    // ------------------------------------------------------------
    // sync and edge
    // ------------------------------------------------------------
    always_comb begin
        next_st       = st;
        next_st.sync1 = pinIn;
        next_st.sync2 = st.sync1;
        next_st.prev  = st.sync2;
        // only settled samples are compared, so one edge gives one pulse
        next_st.pulse = risingSel ? (st.sync2 & ~st.prev)
                                  : (~st.sync2 & st.prev);
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign edgePulse = st.pulse;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    a_edge_single: assert property (edgePulse |=> !edgePulse)
        else $error("fault edge pulse lasted more than one cycle");
endmodule

// File: rtl/bcp_chop_io.sv
// module: chopping pwm channel, phase port and fault interrupt slice
//
// Functional notes
// - 16-bit chop counter counts selected ticks, cpu may read/write anytime.
// - three-bit prescale field picks clock division or external clock.
// - counter zeroed by external reset or match on chosen compare register.
// - period compare match sets flag A; interrupt when its enable is set.
// - output goes low on duty match, high on period match.
// - pwm mode register picks pwm or normal per output pin.
// - master enable register gates each timer output pin.
// - pin holds programmed initial level until its first compare match.
// - chopping waveforms leave on the three channel-zero outputs.
// - port bits zero to two drive the U, V, W high sides.
// - port data read gives stored bit on outputs, pin on inputs.
// - direction bit one makes a port pin an output.
// - fault pin edge raises the fault interrupt request.
// - edge select bit chooses rising or falling detection.
// - 8-bit enable register gates each external interrupt request.
// - enabled event sets request flag; acceptance never clears it.
// - counter count source is the system clock in this use.
//
// The AHB-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
module bcp_chop_io (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        extClkIn,
    input  wire logic        extCntClear,
    output logic [2:0]       chopOut,
    output logic [2:0]       chopOe,
    input  wire logic [7:0]  portIn,
    output logic [7:0]       portOut,
    output logic [7:0]       portOe,
    input  wire logic        faultInterruptPin,
    output logic             chopIrq,
    output logic             faultIrq
);
    typedef struct packed {
        bcp_pkg::bcp_bus_type phase;
        logic [7:0]           addr;
        logic [31:0]          rdata;
        logic [2:0]           prescaleSel;
        logic [2:0]           clearSel;
        logic [3:0]           flags;
        logic [3:0]           irqEn;
        logic [15:0]          chopCounter;
        logic [3:0][15:0]     compare;
        logic [7:0]           pwmModeSelect;
        logic [7:0]           outputMasterEnable;
        logic [7:0]           initialOutputLevel;
        logic [2:0]           started;
        logic [2:0]           level;
        logic [2:0]           pinDrive;
        logic [2:0]           div;
        logic                 extClkPrev;
        logic [7:0]           portDataReg;
        logic [7:0]           portDirectionReg;
        logic [7:0]           edgeSelectReg;
        logic [7:0]           extIrqEnableReg;
        logic                 faultRequest;
    } bcp_chop_state_type;

    bcp_chop_state_type st;
    bcp_chop_state_type next_st;
    logic               tick;
    logic [3:0]         match;
    logic               clearNow;
    logic               faultEdge;
    logic               busWr;
    logic [7:0]         portView;

    // ------------------------------------------------------------
    // fault input
    // ------------------------------------------------------------
    bcp_fault_edge u_fault (
        .clk_sys   (clk_sys),
        .arst_n    (arst_n),
        .pinIn     (faultInterruptPin),
        .risingSel (st.edgeSelectReg[bcp_pkg::FAULT_INTERRUPT_PIN_BIT]),
        .edgePulse (faultEdge)
    );

    // ------------------------------------------------------------
    // count source and compare
    // ------------------------------------------------------------
    always_comb begin
        case (st.prescaleSel)
            bcp_pkg::PSC_DIV1: tick = 1'b1;
            bcp_pkg::PSC_DIV2: tick = st.div[0];
            bcp_pkg::PSC_DIV4: tick = &st.div[1:0];
            bcp_pkg::PSC_DIV8: tick = &st.div;
            default:           tick = extClkIn & ~st.extClkPrev;
        endcase
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_cmp
            assign match[g] = tick && (st.chopCounter == st.compare[g]);
        end
    endgenerate

    always_comb begin
        case (st.clearSel)
            bcp_pkg::CCLR_A: clearNow = match[0];
            bcp_pkg::CCLR_B: clearNow = match[1];
            bcp_pkg::CCLR_C: clearNow = match[2];
            bcp_pkg::CCLR_D: clearNow = match[3];
            default:         clearNow = 1'b0;
        endcase
    end

    assign busWr    = st.phase == bcp_pkg::BUS_WRITE;
    // outputs read back the latch, inputs read the live pin
    assign portView = (st.portDataReg & st.portDirectionReg)
                    | (portIn & ~st.portDirectionReg);

    function automatic logic [31:0] rd_word(input bcp_chop_state_type s,
                                            input logic [7:0] pv);
        logic [31:0] w;
        w = 32'h0;
        case (s.addr)
            bcp_pkg::OFS_CHOP_CHANNEL_CONTROL:
                w[5:0] = {s.clearSel, s.prescaleSel};
            bcp_pkg::OFS_CHOP_CHANNEL_FLAGS:   w[3:0]  = s.flags;
            bcp_pkg::OFS_CHOP_IRQ_ENABLES:     w[3:0]  = s.irqEn;
            bcp_pkg::OFS_CHOP_COUNTER:         w[15:0] = s.chopCounter;
            bcp_pkg::OFS_CHOP_PERIOD_COMPARE:  w[15:0] = s.compare[0];
            bcp_pkg::OFS_CHOP_DUTY_COMPARE_B:  w[15:0] = s.compare[1];
            bcp_pkg::OFS_CHOP_DUTY_COMPARE_C:  w[15:0] = s.compare[2];
            bcp_pkg::OFS_CHOP_DUTY_COMPARE_D:  w[15:0] = s.compare[3];
            bcp_pkg::OFS_PWM_MODE_SELECT:      w[7:0]  = s.pwmModeSelect;
            bcp_pkg::OFS_OUTPUT_MASTER_ENABLE: w[7:0]  = s.outputMasterEnable;
            bcp_pkg::OFS_INITIAL_OUTPUT_LEVEL: w[7:0]  = s.initialOutputLevel;
            bcp_pkg::OFS_PORT_DATA_REG:        w[7:0]  = pv;
            bcp_pkg::OFS_PORT_DIRECTION_REG:   w[7:0]  = s.portDirectionReg;
            bcp_pkg::OFS_EDGE_SELECT_REG:      w[7:0]  = s.edgeSelectReg;
            bcp_pkg::OFS_EXT_IRQ_ENABLE_REG:   w[7:0]  = s.extIrqEnableReg;
            bcp_pkg::OFS_EXT_IRQ_REQUEST_REG:  w[0]    = s.faultRequest;
            default:                           w       = 32'h0;
        endcase
        return w;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st            = st;
        next_st.div        = st.div + 3'h1;
        next_st.extClkPrev = extClkIn;

        if (tick) begin
            next_st.chopCounter = clearNow ? bcp_pkg::RST_HALF
                                           : st.chopCounter + 16'h1;
        end
        if (extCntClear && st.clearSel == bcp_pkg::CCLR_EXT) begin
            next_st.chopCounter = bcp_pkg::RST_HALF;
        end

        for (int i = 0; i < 3; i++) begin
            if (!st.started[i]) begin
                next_st.level[i] = st.initialOutputLevel[i];
            end
            if (st.pwmModeSelect[i] && (match[i + 1] || match[0])) begin
                next_st.started[i] = 1'b1;
                // duty match wins a tie, so equal registers give 0% high
                next_st.level[i]   = match[i + 1] ? 1'b0 : 1'b1;
            end
        end

        // bus data phase; the counter write beats counting in that cycle
        if (busWr) begin
            case (st.addr)
                bcp_pkg::OFS_CHOP_CHANNEL_CONTROL: begin
                    next_st.prescaleSel =
                        hwdata[bcp_pkg::CTRL_PRESCALE_LSB +: 3];
                    next_st.clearSel    = hwdata[bcp_pkg::CTRL_CLEAR_LSB +: 3];
                end
                bcp_pkg::OFS_CHOP_CHANNEL_FLAGS:
                    next_st.flags = st.flags & hwdata[3:0];
                bcp_pkg::OFS_CHOP_IRQ_ENABLES:
                    next_st.irqEn = hwdata[3:0];
                bcp_pkg::OFS_CHOP_COUNTER:
                    next_st.chopCounter = hwdata[15:0];
                bcp_pkg::OFS_CHOP_PERIOD_COMPARE:
                    next_st.compare[0] = hwdata[15:0];
                bcp_pkg::OFS_CHOP_DUTY_COMPARE_B:
                    next_st.compare[1] = hwdata[15:0];
                bcp_pkg::OFS_CHOP_DUTY_COMPARE_C:
                    next_st.compare[2] = hwdata[15:0];
                bcp_pkg::OFS_CHOP_DUTY_COMPARE_D:
                    next_st.compare[3] = hwdata[15:0];
                bcp_pkg::OFS_PWM_MODE_SELECT:
                    next_st.pwmModeSelect = hwdata[7:0];
                bcp_pkg::OFS_OUTPUT_MASTER_ENABLE:
                    next_st.outputMasterEnable = hwdata[7:0];
                bcp_pkg::OFS_INITIAL_OUTPUT_LEVEL:
                    next_st.initialOutputLevel = hwdata[7:0];
                bcp_pkg::OFS_PORT_DATA_REG:
                    next_st.portDataReg = hwdata[7:0];
                bcp_pkg::OFS_PORT_DIRECTION_REG:
                    next_st.portDirectionReg = hwdata[7:0];
                bcp_pkg::OFS_EDGE_SELECT_REG:
                    next_st.edgeSelectReg = hwdata[7:0];
                bcp_pkg::OFS_EXT_IRQ_ENABLE_REG:
                    next_st.extIrqEnableReg = hwdata[7:0];
                bcp_pkg::OFS_EXT_IRQ_REQUEST_REG:
                    next_st.faultRequest = st.faultRequest
                                         & hwdata[bcp_pkg::FAULT_INTERRUPT_PIN_BIT];
                default: ;
            endcase
        end

        // hardware set after the software clear, so a same-cycle event wins
        next_st.flags = next_st.flags | match;
        if (faultEdge && st.extIrqEnableReg[bcp_pkg::FAULT_INTERRUPT_PIN_BIT]) begin
            next_st.faultRequest = 1'b1;
        end
        next_st.pinDrive = next_st.level
                         & next_st.outputMasterEnable[2:0];

        // one wait state on reads keeps a preceding write visible
        if (st.phase == bcp_pkg::BUS_READ) begin
            next_st.rdata = rd_word(st, portView);
            next_st.phase = bcp_pkg::BUS_IDLE;
        end else if (hsel && hready && htrans[1]) begin
            next_st.addr  = haddr[7:0];
            next_st.phase = hwrite ? bcp_pkg::BUS_WRITE : bcp_pkg::BUS_READ;
        end else begin
            next_st.phase = bcp_pkg::BUS_IDLE;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign hreadyout = st.phase != bcp_pkg::BUS_READ;
    assign hrdata    = st.rdata;
    assign hresp     = 1'b0;
    assign chopOut   = st.pinDrive;
    assign chopOe    = st.outputMasterEnable[2:0];
    assign portOut   = st.portDataReg;
    assign portOe    = st.portDirectionReg;
    assign chopIrq   = |(st.flags & st.irqEn);
    assign faultIrq  = st.faultRequest;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    a_clear_on_a: assert property (
        match[0] && st.clearSel == bcp_pkg::CCLR_A && !busWr
        |=> st.chopCounter == 16'h0)
        else $error("counter not cleared on period match");
    a_count_step: assert property (
        tick && !clearNow && !busWr && !extCntClear
        |=> st.chopCounter == $past(st.chopCounter) + 16'h1)
        else $error("counter did not advance on a tick");
    a_flag_a_irq: assert property (
        match[0] && st.irqEn[0] && !busWr |=> st.flags[0] && chopIrq)
        else $error("match A did not raise flag and interrupt");
    a_pwm_low_b: assert property (
        match[1] && st.pwmModeSelect[0] && st.outputMasterEnable[0]
        && !busWr |=> !chopOut[0])
        else $error("output not low after duty match");
    a_pwm_high_a: assert property (
        match[0] && !match[1] && st.pwmModeSelect[0]
        && st.outputMasterEnable[0] && !busWr |=> chopOut[0])
        else $error("output not high after period match");
    a_pin_gated: assert property (!chopOe[1] |-> !chopOut[1])
        else $error("disabled pin drives waveform");
    a_init_level: assert property (
        !st.started[2] && !match[0] && !match[3] && !busWr
        |=> chopOut[2] == (st.initialOutputLevel[2]
                           & st.outputMasterEnable[2]))
        else $error("pin left its initial level before a match");
    a_port_read: assert property (
        st.phase == bcp_pkg::BUS_READ
        && st.addr == bcp_pkg::OFS_PORT_DATA_REG
        |=> hrdata[7:0] == $past(portView) && hreadyout)
        else $error("port read returned wrong mix");
    a_fault_hold: assert property (
        faultIrq && !(busWr
        && st.addr == bcp_pkg::OFS_EXT_IRQ_REQUEST_REG) |=> faultIrq)
        else $error("fault request dropped without a clear");
    a_read_wait: assert property (
        hsel && hready && htrans[1] && !hwrite
        |=> !hreadyout ##1 hreadyout)
        else $error("read answer timing wrong");

    c_period: cover property (match[0] && clearNow);
    c_fault: cover property (faultEdge && st.extIrqEnableReg[0]);
    c_rise: cover property (!chopOut[0] ##1 chopOut[0]);
    c_read: cover property (st.phase == bcp_pkg::BUS_READ);
endmodule

// File: tb/bcp_driver_model.sv
// partner model: three-phase inverter driver stage behind the pins
`timescale 1ns/1ps
module bcp_driver_model (
    input  wire logic [2:0] chopOut,
    input  wire logic [2:0] chopOe,
    input  wire logic [7:0] portOut,
    input  wire logic [7:0] portOe,
    input  wire logic       abnormal,
    input  wire logic       shortLow,
    input  wire logic [4:0] switchLevel,
    output logic [7:0]      portIn,
    output logic            faultPin,
    output logic [2:0]      lowSideOn,
    output logic [2:0]      highSideOn
);
    // a disabled timer pin leaves its low-side gate off
    assign lowSideOn  = chopOut & chopOe;
    assign highSideOn = portOut[2:0] & portOe[2:0];
    assign faultPin   = abnormal;
    // undriven pins 2:0 sit on a pull-down, 7:3 read switchLevel; shortLow mimics a shorted line
    always_comb begin
        portIn = (portOe & portOut) | (~portOe & {switchLevel, 3'h0});
        if (shortLow) begin
            portIn = 8'h00;
        end
    end
endmodule

// File: tb/bldc_chop_pwm_phase_io_tb.sv
// testbench: bus-driven checks of pwm, port and fault paths
`timescale 1ns/1ps
// outputs are compared at the falling edge, where they have settled; the
// bench then returns to just after a rising edge, as the bus tasks expect
`define CHK(n, e, g) \
    begin \
        @(negedge clk_sys); \
        chk(n, 32'(e), 32'(g)); \
        @(posedge clk_sys); \
    end
module bldc_chop_pwm_phase_io_tb;
    logic clk_sys = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d, c1;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2, chopOut, chopOe, lowOn, highOn;
    logic        hreadyout, hresp, chopIrq, faultIrq, faultPin;
    logic        extClkIn = 1'b0, extCntClear = 1'b0;
    logic        abnormal = 1'b0, shortLow = 1'b0;
    logic [7:0]  portIn, portOut, portOe;
    int          badCount = 0, checked = 0, cyc = 0, t0, hi;
    localparam logic [15:0] PER = 16'h0320; // 50 us at 16 MHz
    localparam logic [15:0] DUTY = 16'h0230;

    always #2.5 clk_sys = ~clk_sys;
    always @(negedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            badCount++;
            endOfTest();
        end
    end

    bcp_chop_io bcp_chop_io_i (
        .clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .extClkIn(extClkIn), .extCntClear(extCntClear),
        .chopOut(chopOut), .chopOe(chopOe), .portIn(portIn),
        .portOut(portOut), .portOe(portOe), .faultInterruptPin(faultPin),
        .chopIrq(chopIrq), .faultIrq(faultIrq));
    bcp_driver_model bcp_driver_model_i (
        .chopOut(chopOut), .chopOe(chopOe), .portOut(portOut),
        .portOe(portOe), .abnormal(abnormal), .shortLow(shortLow),
        .switchLevel(5'h15), .portIn(portIn), .faultPin(faultPin),
        .lowSideOn(lowOn), .highSideOn(highOn));

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            badCount++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    // starts right after a rising edge; holds each phase until hready
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
              output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do @(negedge clk_sys); while (hreadyout !== 1'b1);
        @(posedge clk_sys);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(negedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
        @(posedge clk_sys);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        xfer(1'b1, a, v, d);
    endtask
    task rc(input string n, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0, d);
        `CHK(n, e, d)
    endtask
    task cyclesN(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task endOfTest;
        $display("comparisons %0d mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        cyclesN(2);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        // ----------------------------------------------------------
        // reset state and bus basics
        // ----------------------------------------------------------
        `CHK("outs", 22'h0, {chopOut, chopOe, portOut, portOe})
        rc("ctrl", bcp_pkg::OFS_CHOP_CHANNEL_CONTROL, 32'h0);
        wr(8'h40, 32'hffff_ffff);
        rc("unmapped", 8'h40, 32'h0);
        `CHK("okay", 1'b0, hresp)
        wr(bcp_pkg::OFS_CHOP_PERIOD_COMPARE, {16'h0, PER});
        wr(bcp_pkg::OFS_CHOP_DUTY_COMPARE_B, {16'h0, DUTY});
        rc("perA", bcp_pkg::OFS_CHOP_PERIOD_COMPARE, {16'h0, PER});
        rc("dutyB", bcp_pkg::OFS_CHOP_DUTY_COMPARE_B, {16'h0, DUTY});
        $display("test bus done");
        // ----------------------------------------------------------
        // counter: cpu access, external source, external clear
        // ----------------------------------------------------------
        wr(bcp_pkg::OFS_CHOP_CHANNEL_CONTROL, 32'h4);
        wr(bcp_pkg::OFS_CHOP_COUNTER, 32'h1234);
        rc("cnt wr", bcp_pkg::OFS_CHOP_COUNTER, 32'h1234);
        repeat (3) begin
            extClkIn <= 1'b1;
            cyclesN(3);
            extClkIn <= 1'b0;
            cyclesN(3);
        end
        rc("cnt ext", bcp_pkg::OFS_CHOP_COUNTER, 32'h1237);
        wr(bcp_pkg::OFS_CHOP_CHANNEL_CONTROL,
           {26'h0, bcp_pkg::CCLR_EXT, 3'h4});
        extCntClear <= 1'b1;
        cyclesN(2);
        extCntClear <= 1'b0;
        rc("cnt clr", bcp_pkg::OFS_CHOP_COUNTER, 32'h0);
        // internal divisions: 64 cycles hold exactly 64/N ticks
        for (int k = 0; k < 4; k++) begin
            wr(bcp_pkg::OFS_CHOP_CHANNEL_CONTROL, k);
            t0 = cyc;
            xfer(1'b0, bcp_pkg::OFS_CHOP_COUNTER, 32'h0, c1);
            while (cyc != t0 + 64) @(posedge clk_sys);
            xfer(1'b0, bcp_pkg::OFS_CHOP_COUNTER, 32'h0, d);
            `CHK("div", 16'(64 >> k), 16'(d - c1))
        end
        $display("test counter done");
        // ----------------------------------------------------------
        // initial level and output master enable
        // ----------------------------------------------------------
        wr(bcp_pkg::OFS_INITIAL_OUTPUT_LEVEL, 32'h7);
        wr(bcp_pkg::OFS_OUTPUT_MASTER_ENABLE, 32'h5);
        cyclesN(2);
        // pin c is disabled, so only b and d show their initial level
        `CHK("init", 3'h5, chopOut)
        `CHK("oe", 3'h5, chopOe)
        `CHK("lowside", 3'h5, lowOn)
        wr(bcp_pkg::OFS_INITIAL_OUTPUT_LEVEL, 32'h0);
        cyclesN(2);
        `CHK("init0", 3'h0, chopOut)
        $display("test level done");
        // ----------------------------------------------------------
        // chopping waveform on output b, match a clears the counter
        // ----------------------------------------------------------
        wr(bcp_pkg::OFS_CHOP_CHANNEL_CONTROL,
           {26'h0, bcp_pkg::CCLR_A, bcp_pkg::PSC_DIV1});
        wr(bcp_pkg::OFS_CHOP_IRQ_ENABLES, 32'h1);
        wr(bcp_pkg::OFS_OUTPUT_MASTER_ENABLE, 32'h7);
        wr(bcp_pkg::OFS_PWM_MODE_SELECT, 32'h1);
        wr(bcp_pkg::OFS_CHOP_COUNTER, 32'h0);
        cyclesN(900);
        hi = 0;
        c1 = 0;
        repeat (PER + 1) begin
            @(negedge clk_sys);
            hi += chopOut[0];
            c1 |= chopOut[2:1];
        end
        `CHK("high", DUTY + 1, hi)
        `CHK("normal c d", 0, c1)
        `CHK("irq", 1'b1, chopIrq)
        xfer(1'b0, bcp_pkg::OFS_CHOP_CHANNEL_FLAGS, 32'h0, d);
        `CHK("flag a", 1'b1, d[0])
        wr(bcp_pkg::OFS_CHOP_IRQ_ENABLES, 32'h0);
        `CHK("irq off", 1'b0, chopIrq)
        // with b as clear source the counter wraps on the duty match
        wr(bcp_pkg::OFS_CHOP_CHANNEL_CONTROL,
           {26'h0, bcp_pkg::CCLR_B, bcp_pkg::PSC_DIV1});
        wr(bcp_pkg::OFS_CHOP_COUNTER, {16'h0, DUTY});
        rc("clr b", bcp_pkg::OFS_CHOP_COUNTER, 32'h0);
        $display("test pwm done");
        // ----------------------------------------------------------
        // phase port: stored bits on outputs, pins on inputs
        // ----------------------------------------------------------
        wr(bcp_pkg::OFS_PORT_DIRECTION_REG, 32'h07);
        wr(bcp_pkg::OFS_PORT_DATA_REG, 32'hfd);
        `CHK("pout", 16'h07fd, {portOe, portOut})
        `CHK("highside", 3'h5, highOn)
        rc("pread", bcp_pkg::OFS_PORT_DATA_REG, 32'had);
        shortLow <= 1'b1;
        rc("pshort", bcp_pkg::OFS_PORT_DATA_REG, 32'h05);
        shortLow <= 1'b0;
        $display("test port done");
        // ----------------------------------------------------------
        // fault pin edges, enable, sticky request flag
        // ----------------------------------------------------------
        wr(bcp_pkg::OFS_EDGE_SELECT_REG, 32'h1);
        wr(bcp_pkg::OFS_EXT_IRQ_ENABLE_REG, 32'h1);
        abnormal <= 1'b1;
        cyclesN(8);
        `CHK("rise", 1'b1, faultIrq)
        wr(bcp_pkg::OFS_EXT_IRQ_REQUEST_REG, 32'h1);
        rc("keep", bcp_pkg::OFS_EXT_IRQ_REQUEST_REG, 32'h1);
        wr(bcp_pkg::OFS_EXT_IRQ_REQUEST_REG, 32'h0);
        cyclesN(8);
        `CHK("once", 1'b0, faultIrq)
        abnormal <= 1'b0;
        cyclesN(8);
        `CHK("fall ign", 1'b0, faultIrq)
        wr(bcp_pkg::OFS_EDGE_SELECT_REG, 32'h0);
        abnormal <= 1'b1;
        cyclesN(8);
        abnormal <= 1'b0;
        cyclesN(8);
        `CHK("fall", 1'b1, faultIrq)
        wr(bcp_pkg::OFS_EXT_IRQ_REQUEST_REG, 32'h0);
        wr(bcp_pkg::OFS_EXT_IRQ_ENABLE_REG, 32'h0);
        abnormal <= 1'b1;
        cyclesN(8);
        abnormal <= 1'b0;
        cyclesN(8);
        `CHK("masked", 1'b0, faultIrq)
        $display("test fault done");
        endOfTest();
    end
endmodule
